// >>> rtl/scct_consts.vh
// Constants for the share controller config and trim register bank.
// Assumes inclusion by bare name from the bank modules.
`ifndef SCCT_CONSTS_VH
`define SCCT_CONSTS_VH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SCCT_OFS_POLARITY 8'h13
`define SCCT_OFS_DIV_TRIM 8'h14
`define SCCT_OFS_DC_TRIM 8'h15
`define SCCT_OFS_GAIN_OPT 8'h16
`define SCCT_OFS_METHOD_OPT 8'h17
// ----------------------------------------------------------------------
// Nonvolatile copy locations
// ----------------------------------------------------------------------
`define SCCT_NV_POLARITY 16'h8113
`define SCCT_NV_DIV_TRIM 16'h8114
`define SCCT_NV_DC_TRIM 16'h8115
`define SCCT_NV_GAIN_OPT 16'h8116
`define SCCT_NV_METHOD_OPT 16'h8117
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCCT_BIT_POWER_EN_POL 7
`define SCCT_BIT_FAULT_POL 6
`define SCCT_BIT_OUTGOOD_POL 5
`define SCCT_BIT_MAINS_POL 4
`define SCCT_BIT_ORING_POL 3
`define SCCT_BIT_CLAMP_FORCE 2
`define SCCT_BIT_HOST_DRIVE 1
`define SCCT_BIT_LATCH_CLEAR 0
`define SCCT_RANGE_MSB 5
`define SCCT_RANGE_LSB 3
`define SCCT_GAIN_MSB 2
`define SCCT_GAIN_LSB 0
`define SCCT_BIT_SENSE_METHOD 7
// ----------------------------------------------------------------------
// Reset value before the nonvolatile copy arrives
// ----------------------------------------------------------------------
`define SCCT_RESET_VAL 8'h00
`define SCCT_NUM_REGS 5
`endif

// >>> rtl/scct_shadow_mem.v
// Five-entry register storage with registered read data.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/10ps
module scct_shadow_mem
(
  input wire i_ref_clk,
  input wire i_ce,
  input wire i_rst,
  input wire i_wr_en,
  input wire [2:0] i_wr_idx,
  input wire [7:0] i_wr_data,
  input wire [2:0] i_rd_idx,
  output reg [7:0] o_rd_data,
  output wire [39:0] o_all
);
  reg [7:0] mem_reg [0:4];
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_ent
      always @(posedge i_ref_clk)
      begin
        if (i_rst)
          mem_reg[g] <= 8'h00;
        else if (i_ce && i_wr_en && (i_wr_idx == g))
          mem_reg[g] <= i_wr_data;
      end
      assign o_all[8*g+7:8*g] = mem_reg[g];
    end
  endgenerate
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      o_rd_data <= 8'h00;
    else if (i_ce)
      o_rd_data <= (i_rd_idx < 3'h5) ? mem_reg[i_rd_idx] : 8'h00;
  end
endmodule

// >>> rtl/scct_regs.v
// Output polarity, host override and current-sense trim register bank.
// Assumes SMBus byte accesses decoded upstream into write and read strobes
// and a power-up loader that presents nonvolatile bytes by location.
//
// Notes on behaviour
// - Polarity register loads from nonvolatile copy.
// - Trim registers 14h-17h load nonvolatile copies.
// - Bits 7-4 invert four status outputs.
// - Bit 3 sets or-ing gate polarity.
// - Bit 2 forces the share clamp.
// - Bit 1 lets host drive fault pin.
// - Bit 0 write releases latched fault.
// - Divider error trim drives common-mode correction.
// - DC offset trim passes monotonically to analog.
// - Bits 2-0 select current-sense gain.
// - Bit 7 selects resistor or transformer.
// - Trim lock rejects host writes to 14h-17h.
`timescale 1ns/10ps
`include "scct_consts.vh"
module scct_regs
(
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_ce,
  input wire i_nv_valid,
  input wire [15:0] i_nv_addr,
  input wire [7:0] i_nv_data,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_trim_lock,
  input wire i_fault_latch_mode,
  input wire i_power_enable_raw,
  input wire i_fault_raw,
  input wire i_output_good_raw,
  input wire i_mains_good_raw,
  input wire i_oring_on,
  input wire i_clamp_auto,
  output reg [7:0] o_rdata,
  output reg o_rvalid,
  output reg o_power_enable_out,
  output reg o_fault_indicator_out,
  output reg o_output_good_flag,
  output reg o_mains_good_flag,
  output reg o_oring_gate_drive,
  output reg o_share_clamp,
  output reg [7:0] o_div_trim,
  output reg [7:0] o_dc_trim,
  output reg [2:0] o_range_sel,
  output reg [2:0] o_gain_sel,
  output reg o_sense_method
);
  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  // Offsets outside the bank map to index F, which selects no entry
  function [3:0] idx_of;
    input [7:0] a;
    begin
      case (a)
        `SCCT_OFS_POLARITY: idx_of = 4'h0;
        `SCCT_OFS_DIV_TRIM: idx_of = 4'h1;
        `SCCT_OFS_DC_TRIM: idx_of = 4'h2;
        `SCCT_OFS_GAIN_OPT: idx_of = 4'h3;
        `SCCT_OFS_METHOD_OPT: idx_of = 4'h4;
        default: idx_of = 4'hF;
      endcase
    end
  endfunction
  // Nonvolatile locations map onto the same five entries
  function [3:0] nv_idx;
    input [15:0] a;
    begin
      case (a)
        `SCCT_NV_POLARITY: nv_idx = 4'h0;
        `SCCT_NV_DIV_TRIM: nv_idx = 4'h1;
        `SCCT_NV_DC_TRIM: nv_idx = 4'h2;
        `SCCT_NV_GAIN_OPT: nv_idx = 4'h3;
        `SCCT_NV_METHOD_OPT: nv_idx = 4'h4;
        default: nv_idx = 4'hF;
      endcase
    end
  endfunction
  wire [3:0] host_idx = idx_of(i_addr);
  wire [3:0] load_idx = nv_idx(i_nv_addr);
  wire host_hit = (host_idx != 4'hF);
  wire load_hit = i_nv_valid && (load_idx != 4'hF);
  // Trim registers refuse host writes while locked; polarity does not
  wire host_ok = i_wr && host_hit && !(i_trim_lock && (host_idx != 4'h0));
  // --------------------------------------------------------------------
  // Storage write arbitration: power-up load wins over host writes
  // --------------------------------------------------------------------
  wire wr_en = load_hit || host_ok;
  wire [2:0] wr_idx = load_hit ? load_idx[2:0] : host_idx[2:0];
  wire [7:0] wr_data = load_hit ? i_nv_data : i_wdata;
  wire [7:0] mem_rd;
  wire [39:0] all_regs;
  // Reads of unmapped offsets use index 7, which returns zero
  scct_shadow_mem u_mem
  (
    .i_ref_clk(i_ref_clk),
    .i_ce(i_ce),
    .i_rst(i_rst),
    .i_wr_en(wr_en),
    .i_wr_idx(wr_idx),
    .i_wr_data(wr_data),
    .i_rd_idx(host_hit ? host_idx[2:0] : 3'h7),
    .o_rd_data(mem_rd),
    .o_all(all_regs)
  );
  // Pin-facing views of the stored bytes
  wire [7:0] pol = all_regs[7:0];
  wire [7:0] opt1 = all_regs[31:24];
  wire [7:0] opt2 = all_regs[39:32];
  // --------------------------------------------------------------------
  // Fault latch
  // --------------------------------------------------------------------
  // A fault arriving with a clear in the same cycle keeps the latch
  // set, so no event is lost
  reg fault_latch_reg;
  wire clear_wr = host_ok && (host_idx == 4'h0) &&
                  i_wdata[`SCCT_BIT_LATCH_CLEAR];
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
      fault_latch_reg <= 1'b0;
    else if (i_ce)
    begin
      if (i_fault_raw)
        fault_latch_reg <= 1'b1;
      else if (clear_wr)
        fault_latch_reg <= 1'b0;
    end
  end
  // In non-latching mode the pin follows the raw fault directly
  wire fault_level = i_fault_latch_mode ?
                     (fault_latch_reg || i_fault_raw) : i_fault_raw;
  wire fault_src = pol[`SCCT_BIT_HOST_DRIVE] | fault_level;
  // --------------------------------------------------------------------
  // Read return
  // --------------------------------------------------------------------
  // Storage read data lags the strobe by one edge, so the strobe is
  // delayed once to meet it and once more to present it
  // o_rdata holds until the next read
  reg rd_pend_reg;
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      rd_pend_reg <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= `SCCT_RESET_VAL;
    end
    else if (i_ce)
    begin
      rd_pend_reg <= i_rd;
      o_rvalid <= rd_pend_reg;
      if (rd_pend_reg)
        o_rdata <= mem_rd;
    end
  end
  // --------------------------------------------------------------------
  // Status pin outputs
  // --------------------------------------------------------------------
  // Gate drive resets high: with bit 3 clear that is the off level,
  // so the or-ing transistor stays off while reset is held
  // Each status output passes or inverts its raw level, or fault_src for the fault pin, per bits 7-4
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_power_enable_out <= 1'b0;
      o_fault_indicator_out <= 1'b0;
      o_output_good_flag <= 1'b0;
      o_mains_good_flag <= 1'b0;
      o_oring_gate_drive <= 1'b1;
      o_share_clamp <= 1'b0;
    end
    else if (i_ce)
    begin
      o_power_enable_out <= i_power_enable_raw ^
                            pol[`SCCT_BIT_POWER_EN_POL];
      o_fault_indicator_out <= fault_src ^ pol[`SCCT_BIT_FAULT_POL];
      o_output_good_flag <= i_output_good_raw ^
                            pol[`SCCT_BIT_OUTGOOD_POL];
      o_mains_good_flag <= i_mains_good_raw ^ pol[`SCCT_BIT_MAINS_POL];
      // Polarity 0: low means on; polarity 1: low means off
      o_oring_gate_drive <= pol[`SCCT_BIT_ORING_POL] ? i_oring_on :
                            !i_oring_on;
      o_share_clamp <= pol[`SCCT_BIT_CLAMP_FORCE] | i_clamp_auto;
    end
  end
  // --------------------------------------------------------------------
  // Analog path selections
  // --------------------------------------------------------------------
  // Codes 011 and 111 pass through unchanged; the host keeps clear
  // of them since the analog path gives them no meaning
  // Trim values reach the analog path one cycle after they are stored
  always @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_div_trim <= `SCCT_RESET_VAL;
      o_dc_trim <= `SCCT_RESET_VAL;
      o_range_sel <= 3'h0;
      o_gain_sel <= 3'h0;
      o_sense_method <= 1'b0;
    end
    else if (i_ce)
    begin
      o_div_trim <= all_regs[15:8];
      o_dc_trim <= all_regs[23:16];
      o_range_sel <= opt1[`SCCT_RANGE_MSB:`SCCT_RANGE_LSB];
      o_gain_sel <= opt1[`SCCT_GAIN_MSB:`SCCT_GAIN_LSB];
      o_sense_method <= opt2[`SCCT_BIT_SENSE_METHOD];
    end
  end
endmodule

// >>> verification/scct_host_model.sv
// Host model that issues byte writes and reads to the register bank.
// Assumes read data arrives two cycles after the read strobe.
`timescale 1ns/10ps
module scct_host_model
(
  input wire i_ref_clk,
  input wire i_rvalid,
  input wire [7:0] i_rdata,
  output reg o_wr,
  output reg o_rd,
  output reg [7:0] o_addr,
  output reg [7:0] o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h00000;
  task wr_reg(input [7:0] a, input [7:0] d);
  begin
    @(negedge i_ref_clk);
    {o_wr, o_addr, o_wdata} = {1'b1, a, d};
    @(negedge i_ref_clk);
    o_wr = 1'b0;
  end
  endtask
  task rd_reg(input [7:0] a, output [7:0] d, output ok);
    integer n;
  begin
    @(negedge i_ref_clk);
    {o_rd, o_addr} = {1'b1, a};
    @(negedge i_ref_clk);
    o_rd = 1'b0;
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n = n + 1)
    begin
      @(negedge i_ref_clk);
      ok = (i_rvalid === 1'b1);
    end
    d = i_rdata;
  end
  endtask
endmodule

// >>> verification/scct_regs_props.sv
// Concurrent checks on the register bank ports.
// Assumes the clock enable is held high.
`timescale 1ns/10ps
module scct_regs_props
(
  input wire i_ref_clk,
  input wire i_rst,
  input wire i_wr,
  input wire i_rd,
  input wire i_nv_valid,
  input wire i_trim_lock,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_power_enable_raw,
  input wire i_oring_on,
  input wire i_clamp_auto,
  input wire o_rvalid,
  input wire o_power_enable_out,
  input wire o_oring_gate_drive,
  input wire o_share_clamp,
  input wire [7:0] o_dc_trim,
  input wire [2:0] o_gain_sel
);
  reg quiet_reg;
  always @(posedge i_ref_clk)
    quiet_reg <= !i_rst && !i_wr && !i_nv_valid;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  property p_pwr_en;
    $changed(i_power_enable_raw) && quiet_reg |=>
      $changed(o_power_enable_out);
  endproperty
  a_pwr_en: assert property (p_pwr_en) else $error("enable lost");
  property p_ring;
    $changed(i_oring_on) && quiet_reg |=> $changed(o_oring_gate_drive);
  endproperty
  a_ring: assert property (p_ring) else $error("gate lost");
  property p_clamp;
    i_clamp_auto |=> o_share_clamp;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp");
  property p_force;
    i_wr && !i_nv_valid && i_addr == 8'h13 && i_wdata[2] |->
      ##2 o_share_clamp;
  endproperty
  a_force: assert property (p_force) else $error("force");
  property p_rv;
    i_rd |-> ##2 o_rvalid;
  endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_rv1;
    o_rvalid |-> $past(i_rd, 2);
  endproperty
  a_rv1: assert property (p_rv1) else $error("stray rvalid");
  property p_lock;
    i_trim_lock && i_wr && !i_nv_valid && i_addr == 8'h15 ##1
      !i_wr && !i_nv_valid |=> $stable(o_dc_trim);
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_gain;
    i_wr && !i_trim_lock && !i_nv_valid && i_addr == 8'h16 |->
      ##2 o_gain_sel == $past(i_wdata[2:0], 2);
  endproperty
  a_gain: assert property (p_gain) else $error("gain");
  cover property (o_rvalid);
  cover property (i_trim_lock && i_wr);
  cover property (i_nv_valid);
endmodule
bind scct_regs scct_regs_props u_props (.*);

// >>> verification/share_ctrl_config_trim_regs_tb.sv
// Bench for the config and trim register bank.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    cmp_count = cmp_count + 1; \
    if ((g) !== (e)) \
    begin \
      err_total = err_total + 1; \
      $display("Error %0t %h %h", $time, g, e); \
    end \
  end
module share_ctrl_config_trim_regs_tb;
  reg clk, rst, nv, lock, lmode, pwr, flt, og, mg, ron, cla, ok;
  reg [15:0] nva;
  reg [7:0] nvd, rv_d, a;
  reg [2:0] c;
  wire wr, rd, rv, pe_o, fi_o, og_o, mg_o, ring_o, clp_o, meth_o;
  wire [7:0] ad, wd, rdat, divt, dct;
  wire [2:0] rng_o, gn_o;
  integer err_total, cmp_count, i;
  scct_regs dut
  (
    .i_ref_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_nv_valid(nv),
    .i_nv_addr(nva), .i_nv_data(nvd), .i_wr(wr), .i_rd(rd), .i_addr(ad),
    .i_wdata(wd), .i_trim_lock(lock), .i_fault_latch_mode(lmode),
    .i_power_enable_raw(pwr), .i_fault_raw(flt), .i_output_good_raw(og),
    .i_mains_good_raw(mg), .i_oring_on(ron), .i_clamp_auto(cla),
    .o_rdata(rdat), .o_rvalid(rv), .o_power_enable_out(pe_o),
    .o_fault_indicator_out(fi_o), .o_output_good_flag(og_o),
    .o_mains_good_flag(mg_o), .o_oring_gate_drive(ring_o),
    .o_share_clamp(clp_o), .o_div_trim(divt), .o_dc_trim(dct),
    .o_range_sel(rng_o), .o_gain_sel(gn_o), .o_sense_method(meth_o)
  );
  scct_host_model host
  (
    .i_ref_clk(clk), .i_rvalid(rv), .i_rdata(rdat), .o_wr(wr), .o_rd(rd),
    .o_addr(ad), .o_wdata(wd)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task report_and_stop(input bad);
  begin
    err_total = err_total + bad;
    $display("Compares %0d, errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task rchk(input [7:0] ra, input [7:0] e);
  begin
    host.rd_reg(ra, rv_d, ok);
    if (!ok)
      report_and_stop(1'b1);
    else
      `CHK(rv_d, e)
  end
  endtask
  initial
  begin
    err_total = 0;
    cmp_count = 0;
    {nva, nvd} = 24'h000000;
    {rst, nv, lock, lmode, pwr, flt, og, mg, ron, cla} = 10'h200;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (a = 8'h13; a < 8'h19; a = a + 8'h01)
    begin
      {nv, nva, nvd} = {1'b1, 8'h81, a, a ^ 8'hA5};
      @(negedge clk);
    end
    nv = 1'b0;
    for (a = 8'h13; a < 8'h18; a = a + 8'h01)
      rchk(a, a ^ 8'hA5);
    rchk(8'h18, 8'h00);
    $display("Load test done");
    c = 3'd0;
    for (i = 0; i < 6; i = i + 1)
    begin
      host.wr_reg(8'h16, {2'b10, c, 3'd6 - c});
      @(negedge clk);
      `CHK(rng_o, c)
      `CHK(gn_o, 3'd6 - c)
      rchk(8'h16, {2'b10, c, 3'd6 - c});
      c = (c == 3'd2) ? 3'd4 : c + 3'd1;
    end
    host.wr_reg(8'h14, 8'h3C);
    host.wr_reg(8'h15, 8'hC3);
    host.wr_reg(8'h17, 8'h80);
    @(negedge clk);
    `CHK(divt, 8'h3C)
    `CHK(dct, 8'hC3)
    `CHK(meth_o, 1'b1)
    $display("Trim test done");
    host.wr_reg(8'h13, 8'hF8);
    @(negedge clk);
    `CHK({pe_o, fi_o, og_o, mg_o, ring_o, clp_o}, 6'h3C)
    {pwr, flt, og, mg, ron} = 5'h1F;
    @(negedge clk);
    `CHK({pe_o, fi_o, og_o, mg_o, ring_o, clp_o}, 6'h02)
    {pwr, flt, og, mg, ron, cla} = 6'h01;
    host.wr_reg(8'h13, 8'h06);
    @(negedge clk);
    `CHK({pe_o, fi_o, og_o, mg_o, ring_o, clp_o}, 6'h13)
    {lmode, flt, cla} = 3'h6;
    host.wr_reg(8'h13, 8'h00);
    flt = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(fi_o, 1'b1)
    host.wr_reg(8'h13, 8'h01);
    repeat (2) @(negedge clk);
    `CHK(fi_o, 1'b0)
    $display("Output test done");
    lock = 1'b1;
    host.wr_reg(8'h15, 8'h5A);
    rchk(8'h15, 8'hC3);
    host.wr_reg(8'h13, 8'h80);
    rchk(8'h13, 8'h80);
    lock = 1'b0;
    $display("Lock test done");
    report_and_stop(1'b0);
  end
endmodule
